// file: core/pmev_core.sv
// Power event status, enable, control and sleep entry logic
//
// Functional notes
// - Button edges need 15.8 ms unless bypassed
// - Enabled wakeup while sleeping sets wake, resumes
// - Status sets regardless; cleared by writing one
// - Button held 4 s sets override, always interrupts
// - Clock alarm sets bit 10, gated interrupt
// - Button press while working sets bit 8
// - Button press while asleep always wakes
// - Firmware lock release sets bit 5
// - Bus master request sets bit 4
// - Timer top bit toggle sets bit 0
// - Gated events need global interrupt enable
// - Write-only sleep go starts selected sleep
// - Sleep waits for management interrupt serviced
// - Trap enable makes sleep go raise SMI
// - Sleep type decode, 110/111 reserved
// - Global enable low routes events to SMI
module pmev_core import pmev_pkg::*; #(
    parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC,
    parameter int OVERRIDE_CYCLES = OVERRIDE_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    input wire logic power_button_n,
    input wire logic rtc_alarm,
    input wire logic bus_master_req,
    input wire logic timer_msb,
    input wire logic smi_trap_enable,
    input wire logic smi_serviced,
    output logic sci,
    output logic smi_req,
    output logic sleep_active,
    output logic [2:0] sleep_type_active,
    output logic bus_master_reload
);

    // ========================================================
    // State
    typedef struct packed {
        pmev_state_t state;
        logic [15:0] sts;
        logic [15:0] en;
        logic gie;
        logic bm_rld;
        logic [2:0] sleep_type;
        logic [2:0] target;
        logic dbnc_dis;
        logic btn_prev;
        logic rtc_prev;
        logic bm_prev;
        logic tmr_prev;
        logic [31:0] ovr_cnt;
        logic ovr_done;
        logic smi_seen;
        logic sci;
        logic smi;
        logic [7:0] rdata;
    } pmev_core_t;

    pmev_core_t r;
    pmev_core_t n;
    logic btn_level_n;

    // ========================================================
    // Button debounce
    pmev_debounce #(
        .STABLE_CYC(DEBOUNCE_CYCLES)
    ) u_debounce (
        .clk(clk),
        .rst_b(rst_b),
        .raw_n(power_button_n),
        .bypass(r.dbnc_dis),
        .level_n(btn_level_n)
    );

    // ========================================================
    // Event detection and register update
    logic press;
    logic rtc_rise;
    logic bm_rise;
    logic tmr_toggle;
    logic lock_rel;
    logic ovr_hit;
    logic wake_ev;
    logic sleep_wr;
    logic go_req;
    logic type_ok;
    logic working;
    logic [15:0] set_v;
    logic [15:0] clr_v;
    logic [15:0] gated;

    always_comb begin
        n = r;
        working = (r.state != ST_SLEEP);
        press = r.btn_prev & ~btn_level_n;
        rtc_rise = rtc_alarm & ~r.rtc_prev;
        bm_rise = bus_master_req & ~r.bm_prev;
        tmr_toggle = timer_msb ^ r.tmr_prev;
        lock_rel = io_wr && io_addr == OFS_FW_EN && io_wdata[FW_LOCK_REL];
        sleep_wr = io_wr && io_addr == OFS_CTL_HI && io_wdata[CTLH_SLEEP_GO];
        n.btn_prev = btn_level_n;
        n.rtc_prev = rtc_alarm;
        n.bm_prev = bus_master_req;
        n.tmr_prev = timer_msb;

        // ========================================================
        // Override: count while the debounced button is held low
        ovr_hit = 1'b0;
        if (!btn_level_n) begin
            if (r.ovr_cnt < 32'(OVERRIDE_CYCLES - 1)) begin
                n.ovr_cnt = r.ovr_cnt + 32'h1;
            end else if (!r.ovr_done) begin
                ovr_hit = 1'b1;
                n.ovr_done = 1'b1;
            end
        end else begin
            n.ovr_cnt = 32'h0;
            n.ovr_done = 1'b0;
        end

        // ========================================================
        // Wakeup from sleep: button always; alarm, lock release and timer when enabled
        wake_ev = (r.state == ST_SLEEP)
            && (press
            || (rtc_rise && r.en[B_RTC])
            || (lock_rel && r.en[B_LOCK])
            || (tmr_toggle && r.en[B_TMR]));

        // ========================================================
        // Status set sources
        set_v = 16'h0000;
        set_v[B_WAKE] = wake_ev;
        set_v[B_OVR] = ovr_hit;
        set_v[B_RTC] = rtc_rise;
        set_v[B_BTN] = press && working;
        set_v[B_LOCK] = lock_rel;
        set_v[B_BM] = bm_rise;
        set_v[B_TMR] = tmr_toggle;

        // ========================================================
        // Software write-one clears
        clr_v = 16'h0000;
        if (io_wr && io_addr == OFS_STS_LO) begin
            clr_v[7:0] = io_wdata;
        end
        if (io_wr && io_addr == OFS_STS_HI) begin
            clr_v[15:8] = io_wdata;
        end
        // Set wins over a simultaneous clear
        n.sts = ((r.sts & ~clr_v) | set_v) & STS_MASK;

        // ========================================================
        // Register writes
        if (io_wr) begin
            case (io_addr)
                OFS_FUNC_CTL: begin
                    n.dbnc_dis = io_wdata[FUNC_DBNC_DIS];
                end
                OFS_EN_LO: begin
                    n.en[7:0] = io_wdata & EN_MASK[7:0];
                end
                OFS_EN_HI: begin
                    n.en[15:8] = io_wdata & EN_MASK[15:8];
                end
                OFS_CTL_LO: begin
                    n.gie = io_wdata[CTL_GIE];
                    n.bm_rld = io_wdata[CTL_BM_RLD];
                end
                OFS_CTL_HI: begin
                    n.sleep_type = io_wdata[CTLH_TYPE_LO +: 3];
                end
                default: begin
                end
            endcase
        end

        // ========================================================
        // Sleep type decode: full-on and reserved codes start nothing
        case (io_wdata[CTLH_TYPE_LO +: 3])
            3'h1, 3'h2, 3'h3: begin
                type_ok = 1'b1;
            end
            3'h4, SLP_SOFT_OFF: begin
                type_ok = 1'b1;
            end
            default: begin
                type_ok = 1'b0;
            end
        endcase
        go_req = sleep_wr && type_ok;

        // ========================================================
        // Management interrupt: sleep trap or legacy-mode events
        n.smi = (sleep_wr && smi_trap_enable)
            || (!r.gie && |set_v);

        // ========================================================
        // Sleep sequencer
        case (r.state)
            ST_WORK: begin
                if (go_req) begin
                    n.state = ST_WAIT;
                    n.target = io_wdata[CTLH_TYPE_LO +: 3];
                    n.smi_seen = n.smi;
                end
            end
            ST_WAIT: begin
                n.smi_seen = r.smi_seen | r.smi;
                if (smi_serviced && r.smi_seen) begin
                    n.state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wake_ev) begin
                    n.state = ST_WORK;
                    n.target = SLP_FULL_ON;
                end
            end
            default: begin
                n.state = ST_WORK;
            end
        endcase

        // ========================================================
        // Control interrupt: wake and override ungated
        gated = n.sts & n.en & EN_MASK;
        n.sci = n.sts[B_WAKE] || n.sts[B_OVR]
            || (n.gie && (|gated
            || (n.sts[B_BM] && n.bm_rld)));

        // ========================================================
        // Read data, registered the cycle after the strobe
        if (io_rd) begin
            case (io_addr)
                OFS_FUNC_CTL: begin
                    n.rdata = {7'h00, r.dbnc_dis};
                end
                OFS_STS_LO: begin
                    n.rdata = r.sts[7:0];
                end
                OFS_STS_HI: begin
                    n.rdata = r.sts[15:8];
                end
                OFS_EN_LO: begin
                    n.rdata = r.en[7:0];
                end
                OFS_EN_HI: begin
                    n.rdata = r.en[15:8];
                end
                OFS_CTL_LO: begin
                    n.rdata = {6'h00, r.bm_rld, r.gie};
                end
                // Sleep go reads back as zero
                OFS_CTL_HI: begin
                    n.rdata = {3'h0, r.sleep_type, 2'h0};
                end
                default: begin
                    n.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            r <= '{
                state: ST_WORK,
                sts: STS_RESET,
                en: EN_RESET,
                gie: 1'b0,
                bm_rld: 1'b0,
                sleep_type: TYPE_RESET,
                target: SLP_FULL_ON,
                dbnc_dis: 1'b0,
                btn_prev: 1'b1,
                rtc_prev: 1'b0,
                bm_prev: 1'b0,
                tmr_prev: 1'b0,
                ovr_cnt: 32'h0,
                ovr_done: 1'b0,
                smi_seen: 1'b0,
                sci: 1'b0,
                smi: 1'b0,
                rdata: 8'h00
            };
        end else begin
            r <= n;
        end
    end

    // ========================================================
    // Outputs
    assign io_rdata = r.rdata;
    assign sci = r.sci;
    assign smi_req = r.smi;
    // One-hot sleep state bit
    assign sleep_active = r.state[2];
    assign sleep_type_active = r.target;
    assign bus_master_reload = r.bm_rld;

endmodule

// file: core/pmev_debounce.sv
// Power button debounce filter
module pmev_debounce import pmev_pkg::*; #(
    parameter int STABLE_CYC = DEBOUNCE_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic raw_n,
    input wire logic bypass,
    output logic level_n
);

    // ========================================================
    // State
    typedef struct packed {
        logic level;
        logic cand;
        logic [31:0] cnt;
    } pmev_dbnc_t;

    pmev_dbnc_t r;
    pmev_dbnc_t n;

    always_comb begin
        n = r;
        if (bypass) begin
            n.level = raw_n;
            n.cand = raw_n;
            n.cnt = 32'h0;
        end else if (raw_n != r.cand) begin
            n.cand = raw_n;
            n.cnt = 32'h0;
        end else if (r.cand != r.level) begin
            if (r.cnt >= 32'(STABLE_CYC - 1)) begin
                n.level = r.cand;
                n.cnt = 32'h0;
            end else begin
                n.cnt = r.cnt + 32'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            r <= '{level: 1'b1, cand: 1'b1, cnt: 32'h0};
        end else begin
            r <= n;
        end
    end

    assign level_n = r.level;

endmodule

// file: core/pmev_pkg.sv
// Constants and types shared by the power event status and control block
package pmev_pkg;

    // ========================================================
    // I/O offsets (byte addresses)
    localparam logic [7:0] OFS_FUNC_CTL = 8'h07;
    localparam logic [7:0] OFS_STS_LO = 8'h08;
    localparam logic [7:0] OFS_STS_HI = 8'h09;
    localparam logic [7:0] OFS_EN_LO = 8'h0A;
    localparam logic [7:0] OFS_EN_HI = 8'h0B;
    localparam logic [7:0] OFS_CTL_LO = 8'h0C;
    localparam logic [7:0] OFS_CTL_HI = 8'h0D;
    localparam logic [7:0] OFS_FW_EN = 8'h0F;

    // ========================================================
    // Field positions
    localparam int B_WAKE = 15;
    localparam int B_OVR = 11;
    localparam int B_RTC = 10;
    localparam int B_BTN = 8;
    localparam int B_LOCK = 5;
    localparam int B_BM = 4;
    localparam int B_TMR = 0;
    localparam int CTL_GIE = 0;
    localparam int CTL_BM_RLD = 1;
    localparam int CTLH_SLEEP_GO = 5;
    localparam int CTLH_TYPE_LO = 2;
    localparam int FUNC_DBNC_DIS = 0;
    localparam int FW_LOCK_REL = 1;

    // ========================================================
    // Reset values and implemented-bit masks
    localparam logic [15:0] STS_RESET = 16'h0000;
    localparam logic [15:0] EN_RESET = 16'h0000;
    localparam logic [15:0] STS_MASK = 16'h8D31;
    localparam logic [15:0] EN_MASK = 16'h0521;
    localparam logic [2:0] TYPE_RESET = 3'h0;

    // ========================================================
    // Sleep type codes
    localparam logic [2:0] SLP_FULL_ON = 3'h0;
    localparam logic [2:0] SLP_SOFT_OFF = 3'h5;

    // ========================================================
    // Timing
    localparam int CLK_MHZ = 250;
    localparam real DEBOUNCE_MS = 15.8;
    localparam int OVERRIDE_S = 4;
    localparam int DEBOUNCE_CYC = int'($ceil(DEBOUNCE_MS * 1000.0 * CLK_MHZ));
    localparam int OVERRIDE_CYC = OVERRIDE_S * CLK_MHZ * 1000000;

    // ========================================================
    // Sleep sequencer states
    typedef enum logic [2:0] {
        ST_WORK = 3'b001,
        ST_WAIT = 3'b010,
        ST_SLEEP = 3'b100
    } pmev_state_t;

endpackage

// file: testbench/pmev_monitor.sv
// Port checker for the power event block
module pmev_monitor import pmev_pkg::*; (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic rtc_alarm,
    input wire logic bus_master_req,
    input wire logic timer_msb,
    input wire logic smi_trap_enable,
    input wire logic smi_serviced,
    input wire logic sci,
    input wire logic smi_req,
    input wire logic sleep_active,
    input wire logic [2:0] sleep_type_active,
    input wire logic bus_master_reload
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====
    // Shadow of the enables written by software
    logic gie_r;
    logic [1:0] en_r;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gie_r <= 1'b0;
            en_r <= 2'h0;
        end else if (io_wr) begin
            if (io_addr == OFS_CTL_LO) gie_r <= io_wdata[CTL_GIE];
            if (io_addr == OFS_EN_HI) en_r[1] <= io_wdata[2];
            if (io_addr == OFS_EN_LO) en_r[0] <= io_wdata[0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_go;
        io_wr && io_addr == OFS_CTL_HI && io_wdata[CTLH_SLEEP_GO];
    endsequence
    sequence s_rtc;
        $rose(rtc_alarm);
    endsequence
    a_trap_smi: assert property (s_go ##0 smi_trap_enable |=> smi_req)
        else $error("no SMI after sleep go");
    a_legacy_smi: assert property (s_rtc ##0 !gie_r |=> smi_req)
        else $error("no SMI for alarm in legacy mode");
    a_rtc_sci: assert property (s_rtc ##0 gie_r && en_r[1] |=> sci)
        else $error("no SCI for enabled alarm");
    a_tmr_sci: assert property (
        $changed(timer_msb) && gie_r && en_r[0] |=> sci)
        else $error("no SCI for timer toggle");
    a_bm_sci: assert property (
        $rose(bus_master_req) && gie_r && bus_master_reload |=> sci)
        else $error("no SCI for bus master");
    a_sleep_wait: assert property (
        $rose(sleep_active) |-> $past(smi_serviced))
        else $error("sleep without serviced SMI");
    a_sleep_type: assert property (
        sleep_active |-> sleep_type_active inside {[3'h1:3'h5]})
        else $error("sleep with bad type");
    a_go_reads_zero: assert property (
        io_rd && io_addr == OFS_CTL_HI |=> !io_rdata[5])
        else $error("sleep go read as one");
endmodule

bind pmev_core pmev_monitor u_pmev_monitor (.clk, .rst_b, .io_addr, .io_wr,
    .io_rd, .io_wdata, .io_rdata, .rtc_alarm, .bus_master_req, .timer_msb,
    .smi_trap_enable, .smi_serviced, .sci, .smi_req, .sleep_active,
    .sleep_type_active, .bus_master_reload);

// file: testbench/pmev_partner.sv
// Model of the button, clock alarm, bus masters and timer
module pmev_partner (
    input wire logic clk,
    output logic power_button_n,
    output logic rtc_alarm,
    output logic bus_master_req,
    output logic timer_msb
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        power_button_n = 1'b1;
        rtc_alarm = 1'b0;
        bus_master_req = 1'b0;
        timer_msb = 1'b0;
    end
    // Button held n cycles, then back to its pull-up level
    task automatic press(input int n);
        @(negedge clk) power_button_n = 1'b0;
        repeat (n) @(negedge clk);
        power_button_n = 1'b1;
    endtask
    task automatic pulse(input bit bm);
        @(negedge clk);
        if (bm) bus_master_req = 1'b1;
        else rtc_alarm = 1'b1;
        repeat (2) @(negedge clk);
        bus_master_req = 1'b0;
        rtc_alarm = 1'b0;
    endtask
    task automatic toggle();
        @(negedge clk) timer_msb = ~timer_msb;
    endtask
endmodule

// file: testbench/test_acpi_pm1_event_control.sv
// Self-checking bench for the power event block
module test_acpi_pm1_event_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DB = 8;
    logic clk, rst_b, io_wr, io_rd, smi_trap_enable, smi_serviced;
    logic [7:0] io_addr, io_wdata, io_rdata;
    logic power_button_n, rtc_alarm, bus_master_req, timer_msb, sci;
    logic smi_req, sleep_active, bus_master_reload;
    logic [2:0] sleep_type_active;
    logic [7:0] offs [8] = '{8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C,
        8'h0D, 8'h20};
    int num_errors = 0, checks = 0;
    always #2 clk = ~clk;
    pmev_core #(.DEBOUNCE_CYCLES(DB), .OVERRIDE_CYCLES(40)) u_pmev_core (
        .clk, .rst_b, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata,
        .power_button_n, .rtc_alarm, .bus_master_req, .timer_msb,
        .smi_trap_enable, .smi_serviced, .sci, .smi_req, .sleep_active,
        .sleep_type_active, .bus_master_reload);
    pmev_partner u_pmev_partner (.clk, .power_button_n, .rtc_alarm,
        .bus_master_req, .timer_msb);
    // ====
    // Access and compare tasks
    task automatic chk(input string what, input logic [7:0] exp, got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(negedge clk);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge clk);
        io_wr = 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, exp);
        @(negedge clk);
        io_addr = a;
        io_rd = 1'b1;
        @(negedge clk);
        io_rd = 1'b0;
        chk($sformatf("offset %h", a), exp, io_rdata);
    endtask
    task automatic settle();
        repeat (DB + 4) @(negedge clk);
    endtask
    task automatic close_out();
        $display("Checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        close_out();
    end
    // ====
    // Tests
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_addr = 8'h00;
        io_wdata = 8'h00;
        smi_trap_enable = 1'b0;
        smi_serviced = 1'b0;
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        foreach (offs[i]) rc(offs[i], 8'h00);
        $display("Test reset values done");
        wr(8'h0A, 8'h01);
        wr(8'h0B, 8'h05);
        u_pmev_partner.pulse(1'b0);
        rc(8'h09, 8'h04);
        chk("sci", 8'h00, {7'h0, sci});
        wr(8'h09, 8'h04);
        rc(8'h09, 8'h00);
        wr(8'h0C, 8'h03);
        rc(8'h0C, 8'h03);
        chk("reload", 8'h01, {7'h0, bus_master_reload});
        u_pmev_partner.pulse(1'b0);
        chk("sci", 8'h01, {7'h0, sci});
        wr(8'h09, 8'h04);
        chk("sci", 8'h00, {7'h0, sci});
        $display("Test clock alarm done");
        for (int i = 0; i < 2; i++) begin
            u_pmev_partner.toggle();
            rc(8'h08, 8'h01);
            chk("sci", 8'h01, {7'h0, sci});
            wr(8'h08, 8'h01);
        end
        wr(8'h0F, 8'h02);
        rc(8'h08, 8'h20);
        rc(8'h0F, 8'h00);
        chk("sci", 8'h00, {7'h0, sci});
        wr(8'h08, 8'h20);
        u_pmev_partner.pulse(1'b1);
        rc(8'h08, 8'h10);
        chk("sci", 8'h01, {7'h0, sci});
        wr(8'h08, 8'h10);
        $display("Test timer lock bus done");
        u_pmev_partner.press(3);
        settle();
        rc(8'h09, 8'h00);
        u_pmev_partner.press(60);
        rc(8'h09, 8'h09);
        settle();
        wr(8'h09, 8'h09);
        wr(8'h07, 8'h01);
        u_pmev_partner.press(3);
        rc(8'h09, 8'h01);
        settle();
        wr(8'h09, 8'h01);
        wr(8'h07, 8'h00);
        $display("Test button done");
        wr(8'h0B, 8'h04);
        smi_trap_enable = 1'b1;
        wr(8'h0D, 8'h24);
        chk("smi", 8'h01, {7'h0, smi_req});
        chk("sleep", 8'h00, {7'h0, sleep_active});
        smi_serviced = 1'b1;
        @(negedge clk);
        smi_serviced = 1'b0;
        chk("sleep", 8'h01, {7'h0, sleep_active});
        chk("type", 8'h01, {5'h0, sleep_type_active});
        rc(8'h0D, 8'h04);
        u_pmev_partner.press(15);
        settle();
        chk("sleep", 8'h00, {7'h0, sleep_active});
        rc(8'h09, 8'h80);
        wr(8'h09, 8'h80);
        wr(8'h0D, 8'h38);
        smi_serviced = 1'b1;
        @(negedge clk);
        smi_serviced = 1'b0;
        repeat (2) @(negedge clk);
        chk("sleep", 8'h00, {7'h0, sleep_active});
        $display("Test sleep done");
        close_out();
    end
endmodule
